// ==== hw/mdcap_pkg.sv ====
package mdcap_pkg;

    // Bus and array dimensions.
    localparam int CA_W = 6;
    localparam int BANKS = 8;
    localparam int BA_W = 3;
    localparam int ROW_W = 17;
    localparam int COL_W = 10;
    localparam int MA_W = 6;
    localparam int OP_W = 8;

    // First-edge opcodes, lanes 4 down to 0.
    localparam logic [4:0] OPC_MPC = 5'h00;
    localparam logic [4:0] OPC_RD1 = 5'h02;
    localparam logic [4:0] OPC_WR1 = 5'h04;
    localparam logic [4:0] OPC_MRW1 = 5'h06;
    localparam logic [4:0] OPC_REF = 5'h08;
    localparam logic [4:0] OPC_MWR1 = 5'h0C;
    localparam logic [4:0] OPC_MRR1 = 5'h0E;
    localparam logic [4:0] OPC_PRE = 5'h10;
    localparam logic [4:0] OPC_CAS2 = 5'h12;
    localparam logic [4:0] OPC_SRX = 5'h14;
    localparam logic [4:0] OPC_MRW2 = 5'h16;
    localparam logic [4:0] OPC_SRE = 5'h18;

    // Lane positions of the single-bit fields.
    localparam int CA_ACT = 0;
    localparam int CA_ACT2 = 1;
    localparam int CA_RFM = 3;
    localparam int CA_C9 = 4;
    localparam int CA_FLAG = 5;

    // Strobe option mode register: address, bit positions, reset value.
    localparam logic [MA_W-1:0] MR_STROBE_ADDR = 6'h01;
    localparam int MR_PRE_BIT = 3;
    localparam int MR_POST_BIT = 7;
    localparam logic [OP_W-1:0] MR_STROBE_RST = 8'h00;

    // Strobe lengths counted in link half-cycles.
    localparam logic [7:0] PRE_HALVES = 8'h04;
    localparam logic [7:0] POST_SHORT_HALVES = 8'h01;
    localparam logic [7:0] POST_LONG_HALVES = 8'h03;
    localparam logic [7:0] BL16_HALVES = 8'h10;
    localparam logic [7:0] BL32_HALVES = 8'h20;

    // Decoded command codes.
    typedef enum logic [3:0] {
        CMD_NONE = 4'b0000,
        CMD_ACT = 4'b0001,
        CMD_RD = 4'b0010,
        CMD_WR = 4'b0011,
        CMD_MWR = 4'b0100,
        CMD_PRE = 4'b0101,
        CMD_REF = 4'b0110,
        CMD_MRW = 4'b0111,
        CMD_MRR = 4'b1000,
        CMD_MPC = 4'b1001,
        CMD_SRE = 4'b1010,
        CMD_SRX = 4'b1011
    } mdcap_cmd_t;

    typedef enum logic {
        FR_FIRST = 1'b0,
        FR_SECOND = 1'b1
    } mdcap_frame_t;

    typedef enum logic [2:0] {
        SB_IDLE = 3'b000,
        SB_LAT = 3'b001,
        SB_PRE = 3'b010,
        SB_DATA = 3'b011,
        SB_POST = 3'b100
    } mdcap_strobe_t;

endpackage

// ==== hw/mdcap_row_mem.sv ====
`timescale 1ns/10ps

// Open-row table, one entry per bank, with a registered read port.
module mdcap_row_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 17
) (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Write port.
    input wire logic i_we,
    input wire logic [$clog2(DEPTH)-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    // Read port.
    input wire logic [$clog2(DEPTH)-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    initial
    begin
        if (DEPTH < 2 || WIDTH < 1)
        begin
            $error("mdcap_row_mem: unsupported geometry");
        end
    end

    // Storage carries no reset; a bank is only read after it was activated.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // Registered read data.
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_rdata <= '0;
        end
        else
        begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule

// ==== hw/mdcap_cmd_decoder.sv ====
`timescale 1ns/10ps

// How it works
// - Non-deselect commands span two rising edges; deselect is never latched.
// - The three-bit bank field picks the bank a command acts on.
// - All-banks flag on precharge or refresh hits every bank, bank field ignored.
// - Auto-precharge flag closes the bank after the access; otherwise it stays open.
// - With on-the-fly enabled, burst flag picks 32 or 16, except masked write which stays at 16; else ignored.
// - Column bits 1:0 are implied zero; writes send column bits 3:2 low.
// - Refresh lane 3 marks refresh management only when the indicator reads one.
// - Activate opens the seventeen-bit row built from both activate halves.
// - A read strobe burst runs to completion and is never cut short.
// - Read preamble is two clocks, static or with one toggle, per mode bit.
// - Read postamble is half a clock, or one and a half when extended.
module mdcap_cmd_decoder
    import mdcap_pkg::*;
#(
    parameter int READ_LAT = 14
) (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Command pins from the controller.
    input wire logic i_link_ck,
    input wire logic i_cke,
    input wire logic i_cs,
    input wire logic [CA_W-1:0] i_ca,
    // Static configuration.
    input wire logic i_otf_bl_en,
    input wire logic i_rfm_required,
    // Decoded command.
    output logic o_cmd_valid,
    output mdcap_cmd_t o_cmd_code,
    output logic [BA_W-1:0] o_bank,
    output logic [BANKS-1:0] o_bank_sel,
    output logic [ROW_W-1:0] o_row,
    output logic [COL_W-1:0] o_col,
    output logic o_auto_precharge_flag,
    output logic o_burst32,
    output logic o_refresh_management,
    output logic o_proto_err,
    // Bank and mode state.
    output logic [BANKS-1:0] o_bank_open,
    output logic o_pre_toggle,
    output logic o_post_long,
    // Read strobe pin.
    output logic o_dqs_out,
    output logic o_dqs_oe_n,
    output logic o_strobe_busy
);

    initial
    begin
        if (READ_LAT < 1 || READ_LAT > 100)
        begin
            $error("mdcap_cmd_decoder: READ_LAT out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and link clock edge detection.

    logic ck_meta, ck_sync, ck_prev, cke_meta, cke_sync, cs_meta, cs_sync;
    logic [CA_W-1:0] ca_meta, ca_sync;
    logic link_rise, link_edge;

    // All pins take the same two-stage path so data stays aligned to the clock.
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            {ck_meta, ck_sync, ck_prev} <= 3'h0;
            {cke_meta, cke_sync, cs_meta, cs_sync} <= 4'h0;
            ca_meta <= '0;
            ca_sync <= '0;
        end
        else
        begin
            ck_meta <= i_link_ck;
            ck_sync <= ck_meta;
            ck_prev <= ck_sync;
            cke_meta <= i_cke;
            cke_sync <= cke_meta;
            cs_meta <= i_cs;
            cs_sync <= cs_meta;
            ca_meta <= i_ca;
            ca_sync <= ca_meta;
        end
    end

    assign link_rise = ck_sync & ~ck_prev;
    assign link_edge = ck_sync ^ ck_prev;

    ////////////////////////////////////////////////////////////////////////
    // Two-edge framing.

    mdcap_frame_t frame_reg;
    logic [CA_W-1:0] e1_reg;
    logic fire;
    logic [4:0] opc;

    // A frame opens only on chip select high, so deselect is dropped.
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            frame_reg <= FR_FIRST;
            e1_reg <= '0;
        end
        else if (link_rise)
        begin
            case (frame_reg)
                FR_FIRST:
                begin
                    if (cke_sync && cs_sync)
                    begin
                        e1_reg <= ca_sync;
                        frame_reg <= FR_SECOND;
                    end
                end
                FR_SECOND:
                begin
                    frame_reg <= FR_FIRST;
                end
                default:
                begin
                    frame_reg <= FR_FIRST;
                end
            endcase
        end
    end

    assign fire = link_rise && (frame_reg == FR_SECOND);
    assign opc = e1_reg[4:0];

    ////////////////////////////////////////////////////////////////////////
    // Pending first halves and the open-row table.

    logic act_pend, col_pend, mrw_pend, mrr_pend, mpc_pend;
    mdcap_cmd_t col_kind;
    logic [BA_W-1:0] act_ba, col_ba;
    logic [6:0] act_hi;
    logic col_ap, col_bl, col_c9;
    logic [MA_W-1:0] mrw_ma;
    logic mrw_op7;
    logic act2_fire, is_act;
    logic [ROW_W-1:0] act_row, stored_row;
    logic [OP_W-1:0] mrw_op, strobe_mr_reg;

    assign is_act = e1_reg[CA_ACT];
    // The second half is recognised only with lanes 1 and 0 both high and a first half pending.
    assign act2_fire = fire && is_act && e1_reg[CA_ACT2] && act_pend;
    // Row bits 16 and 15:10 came with the first half, 9:0 arrive now.
    assign act_row = {act_hi, e1_reg[5:2], ca_sync};
    assign mrw_op = {mrw_op7, e1_reg[CA_FLAG], ca_sync};

    mdcap_row_mem #(
        .DEPTH(BANKS),
        .WIDTH(ROW_W)
    ) u_row_mem (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_we(act2_fire),
        .i_waddr(act_ba),
        .i_wdata(act_row),
        .i_raddr(col_ba),
        .o_rdata(stored_row)
    );

    ////////////////////////////////////////////////////////////////////////
    // Command decode, bank state and mode register.

    logic rd_start, rd_bl32;

    // Every completed command clears stale first halves, so a pair split by
    // another command is flagged rather than joined wrongly.
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            {act_pend, col_pend, mrw_pend, mrr_pend, mpc_pend} <= 5'h00;
            col_kind <= CMD_NONE;
            {act_ba, col_ba} <= 6'h00;
            act_hi <= 7'h00;
            {col_ap, col_bl, col_c9, mrw_op7} <= 4'h0;
            mrw_ma <= '0;
            strobe_mr_reg <= MR_STROBE_RST;
            o_bank_open <= '0;
            o_cmd_valid <= 1'b0;
            o_cmd_code <= CMD_NONE;
            o_bank <= '0;
            o_bank_sel <= '0;
            o_row <= '0;
            o_col <= '0;
            {o_auto_precharge_flag, o_burst32, o_refresh_management} <= 3'h0;
            o_proto_err <= 1'b0;
            {rd_start, rd_bl32} <= 2'h0;
        end
        else
        begin
            o_cmd_valid <= 1'b0;
            o_proto_err <= 1'b0;
            rd_start <= 1'b0;
            if (fire)
            begin
                {act_pend, col_pend, mrw_pend, mrr_pend, mpc_pend} <= 5'h00;
                o_bank <= ca_sync[BA_W-1:0];
                o_bank_sel <= BANKS'(1) << ca_sync[BA_W-1:0];
                o_auto_precharge_flag <= 1'b0;
                o_burst32 <= 1'b0;
                o_refresh_management <= 1'b0;
                if (is_act && !e1_reg[CA_ACT2])
                begin
                    act_pend <= 1'b1;
                    act_ba <= ca_sync[BA_W-1:0];
                    act_hi <= {ca_sync[3], e1_reg[5:2], ca_sync[5], ca_sync[4]};
                end
                else if (is_act)
                begin
                    // A second half with no first half pending is refused.
                    o_proto_err <= !act_pend;
                    if (act_pend)
                    begin
                        o_cmd_valid <= 1'b1;
                        o_cmd_code <= CMD_ACT;
                        o_bank <= act_ba;
                        o_bank_sel <= BANKS'(1) << act_ba;
                        o_row <= act_row;
                        o_bank_open[act_ba] <= 1'b1;
                    end
                end
                else
                begin
                    case (opc)
                        OPC_RD1, OPC_WR1, OPC_MWR1:
                        begin
                            col_pend <= 1'b1;
                            col_kind <= (opc == OPC_RD1) ? CMD_RD :
                                        (opc == OPC_WR1) ? CMD_WR : CMD_MWR;
                            col_ba <= ca_sync[BA_W-1:0];
                            col_ap <= ca_sync[CA_FLAG];
                            col_c9 <= ca_sync[CA_C9];
                            // Masked write is fixed at burst 16.
                            col_bl <= e1_reg[CA_FLAG] && i_otf_bl_en && (opc != OPC_MWR1);
                        end
                        OPC_CAS2:
                        begin
                            mpc_pend <= 1'b0;
                            o_proto_err <= !(col_pend || mrr_pend || mpc_pend);
                            if (col_pend)
                            begin
                                o_cmd_valid <= 1'b1;
                                o_cmd_code <= col_kind;
                                o_bank <= col_ba;
                                o_bank_sel <= BANKS'(1) << col_ba;
                                o_row <= stored_row;
                                // Low two column bits are implied zero.
                                o_col <= {col_c9, e1_reg[CA_FLAG], ca_sync, 2'b00};
                                o_auto_precharge_flag <= col_ap;
                                o_burst32 <= col_bl;
                                if (col_ap)
                                begin
                                    o_bank_open[col_ba] <= 1'b0;
                                end
                                rd_start <= (col_kind == CMD_RD);
                                rd_bl32 <= col_bl;
                            end
                            else if (mrr_pend)
                            begin
                                o_cmd_valid <= 1'b1;
                                o_cmd_code <= CMD_MRR;
                            end
                        end
                        OPC_MRW1:
                        begin
                            mrw_pend <= 1'b1;
                            mrw_ma <= ca_sync;
                            mrw_op7 <= e1_reg[CA_FLAG];
                        end
                        OPC_MRW2:
                        begin
                            o_proto_err <= !mrw_pend;
                            if (mrw_pend)
                            begin
                                o_cmd_valid <= 1'b1;
                                o_cmd_code <= CMD_MRW;
                                if (mrw_ma == MR_STROBE_ADDR)
                                begin
                                    strobe_mr_reg <= mrw_op;
                                end
                            end
                        end
                        OPC_MRR1:
                        begin
                            mrr_pend <= 1'b1;
                        end
                        OPC_MPC:
                        begin
                            mpc_pend <= 1'b1;
                            o_cmd_valid <= 1'b1;
                            o_cmd_code <= CMD_MPC;
                        end
                        OPC_REF, OPC_PRE:
                        begin
                            o_cmd_valid <= 1'b1;
                            o_cmd_code <= (opc == OPC_REF) ? CMD_REF : CMD_PRE;
                            if (e1_reg[CA_FLAG])
                            begin
                                o_bank_sel <= '1;
                            end
                            if (opc == OPC_REF)
                            begin
                                // Lane 3 counts only when the indicator is set.
                                o_refresh_management <= i_rfm_required && ca_sync[CA_RFM];
                            end
                            else if (e1_reg[CA_FLAG])
                            begin
                                o_bank_open <= '0;
                            end
                            else
                            begin
                                o_bank_open[ca_sync[BA_W-1:0]] <= 1'b0;
                            end
                        end
                        OPC_SRE, OPC_SRX:
                        begin
                            o_cmd_valid <= 1'b1;
                            o_cmd_code <= (opc == OPC_SRE) ? CMD_SRE : CMD_SRX;
                        end
                        default:
                        begin
                            o_proto_err <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end

    assign o_pre_toggle = strobe_mr_reg[MR_PRE_BIT];
    assign o_post_long = strobe_mr_reg[MR_POST_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Read strobe sequencer, stepped on every link clock edge.

    localparam logic [7:0] LAT_HALVES = 8'(2 * READ_LAT);
    mdcap_strobe_t sb_reg;
    logic [7:0] sb_cnt, sb_step;
    logic sb_bl32;

    assign sb_step = sb_cnt + 8'h01;

    // A started burst always runs out; reads arriving meanwhile are not queued.
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sb_reg <= SB_IDLE;
            sb_cnt <= 8'h00;
            sb_bl32 <= 1'b0;
            o_dqs_out <= 1'b0;
            o_dqs_oe_n <= 1'b1;
            o_strobe_busy <= 1'b0;
        end
        else
        begin
            o_strobe_busy <= (sb_reg != SB_IDLE) || rd_start;
            if (sb_reg == SB_IDLE)
            begin
                o_dqs_oe_n <= 1'b1;
                o_dqs_out <= 1'b0;
                if (rd_start)
                begin
                    sb_reg <= SB_LAT;
                    sb_cnt <= 8'h00;
                    sb_bl32 <= rd_bl32;
                end
            end
            else if (link_edge)
            begin
                sb_cnt <= sb_step;
                case (sb_reg)
                    SB_LAT:
                    begin
                        if (sb_step == LAT_HALVES)
                        begin
                            sb_reg <= SB_PRE;
                            sb_cnt <= 8'h00;
                            o_dqs_oe_n <= 1'b0;
                            o_dqs_out <= 1'b0;
                        end
                    end
                    SB_PRE:
                    begin
                        // Toggle mode raises the strobe once in the third half.
                        o_dqs_out <= o_pre_toggle && (sb_step == PRE_HALVES - 8'h02);
                        if (sb_step == PRE_HALVES)
                        begin
                            sb_reg <= SB_DATA;
                            sb_cnt <= 8'h00;
                            o_dqs_out <= 1'b1;
                        end
                    end
                    SB_DATA:
                    begin
                        o_dqs_out <= ~sb_step[0];
                        if (sb_step == (sb_bl32 ? BL32_HALVES : BL16_HALVES))
                        begin
                            sb_reg <= SB_POST;
                            sb_cnt <= 8'h00;
                            o_dqs_out <= 1'b0;
                        end
                    end
                    SB_POST:
                    begin
                        o_dqs_out <= sb_step[0];
                        if (sb_step == (o_post_long ? POST_LONG_HALVES : POST_SHORT_HALVES))
                        begin
                            sb_reg <= SB_IDLE;
                            o_dqs_oe_n <= 1'b1;
                            o_dqs_out <= 1'b0;
                        end
                    end
                    default:
                    begin
                        sb_reg <= SB_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// ==== testbench/mdcap_monitor.sv ====
`timescale 1ns/10ps
// Port-level checks for the command decoder.
module mdcap_monitor
    import mdcap_pkg::*;
(
    // Clock, reset and configuration.
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_otf_bl_en,
    input wire logic i_rfm_required,
    // Decoded command and state.
    input wire logic o_cmd_valid,
    input wire mdcap_cmd_t o_cmd_code,
    input wire logic [BA_W-1:0] o_bank,
    input wire logic [BANKS-1:0] o_bank_sel,
    input wire logic [COL_W-1:0] o_col,
    input wire logic o_auto_precharge_flag,
    input wire logic o_burst32,
    input wire logic o_refresh_management,
    input wire logic o_proto_err,
    input wire logic [BANKS-1:0] o_bank_open,
    input wire logic o_dqs_out,
    input wire logic o_dqs_oe_n,
    input wire logic o_strobe_busy
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    ////////////////////////////////////////
    // Column commands share several checks, so they are decoded once here.
    logic v;
    logic col_cmd;
    assign v = o_cmd_valid;
    assign col_cmd = v && (o_cmd_code inside {CMD_RD, CMD_WR, CMD_MWR});
    a_valid_pulse: assert property (v |=> !v)
        else $error("command valid longer than one cycle");
    a_err_exclusive: assert property (!(v && o_proto_err))
        else $error("error and valid together");
    a_col_low_zero: assert property (col_cmd |-> o_col[1:0] == 2'h0)
        else $error("low column bits not zero");
    a_act_bank_sel: assert property (v && o_cmd_code == CMD_ACT |-> o_bank_sel == 8'h01 << o_bank)
        else $error("bank select does not match bank");
    a_act_opens: assert property (v && o_cmd_code == CMD_ACT |-> ##[0:1] o_bank_open[o_bank])
        else $error("activated bank not open");
    a_ap_closes: assert property (col_cmd && o_auto_precharge_flag |-> ##[0:1] !o_bank_open[o_bank])
        else $error("auto precharge left bank open");
    a_all_pre_clears: assert property (v && o_cmd_code == CMD_PRE && o_bank_sel == 8'hFF
        |-> ##[0:1] o_bank_open == 8'h00)
        else $error("all-bank precharge left a bank open");
    a_otf_ignored: assert property (v && (!i_otf_bl_en || o_cmd_code == CMD_MWR) |-> !o_burst32)
        else $error("burst 32 without on-the-fly enable");
    a_rfm_gate: assert property (v && o_refresh_management |-> i_rfm_required && o_cmd_code == CMD_REF)
        else $error("refresh management without indicator");
    a_drive_in_seq: assert property (!o_dqs_oe_n |-> o_strobe_busy)
        else $error("strobe driven outside a read");
    a_pre_starts_low: assert property ($fell(o_dqs_oe_n) |-> !o_dqs_out)
        else $error("preamble does not start low");
    c_act: cover property (v && o_cmd_code == CMD_ACT);
    c_err: cover property (o_proto_err);
    c_strobe: cover property ($fell(o_dqs_oe_n));
endmodule
bind mdcap_cmd_decoder mdcap_monitor mdcap_monitor_i (.*);

// ==== testbench/mdcap_ctrl_model.sv ====
`timescale 1ns/10ps
// Controller model: the link clock runs only while a task drives it, deselects included; lanes move while it is low.
module mdcap_ctrl_model
    import mdcap_pkg::*;
(
    // Link pins toward the decoder.
    output logic o_link_ck,
    output logic o_cke,
    output logic o_cs,
    output logic [CA_W-1:0] o_ca
);
    initial
    begin
        o_link_ck = 1'b0;
        o_cke = 1'b1;
        o_cs = 1'b0;
        o_ca = 6'h2A;
    end
    ////////////////////////////////////////
    // One 125 ns link period carrying the given select and lanes.
    task automatic edge_out(input logic cs, input logic [CA_W-1:0] ca);
        o_cs = cs;
        o_ca = ca;
        #62.5 o_link_ck = 1'b1;
        #62.5 o_link_ck = 1'b0;
    endtask
    // Two rising edges per command; afterwards the lanes no longer hold the last value.
    task automatic send(input logic cs, input logic [CA_W-1:0] a, b);
        edge_out(cs, a);
        edge_out(1'b0, b);
        o_ca = ~b;
    endtask
    // Deselects with a moving pattern while a read strobe plays out.
    task automatic run(input int n);
        repeat (n) edge_out(1'b0, o_ca ^ 6'h15);
    endtask
endmodule

// ==== testbench/mdcap_cmd_decoder_test.sv ====
`timescale 1ns/10ps
// Self-checking bench for the command decoder.
module mdcap_cmd_decoder_test
    import mdcap_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_otf_bl_en = 1'b0;
    logic i_rfm_required = 1'b1;
    logic i_link_ck, i_cke, i_cs, o_cmd_valid, o_auto_precharge_flag, o_burst32;
    logic o_refresh_management, o_proto_err, o_pre_toggle, o_post_long, o_dqs_out;
    logic o_dqs_oe_n, o_strobe_busy, ap_c, b32_c, rfm_c;
    logic dqs_d = 1'b0;
    logic [CA_W-1:0] i_ca;
    mdcap_cmd_t o_cmd_code;
    logic [BA_W-1:0] o_bank;
    logic [BANKS-1:0] o_bank_sel, o_bank_open;
    logic [ROW_W-1:0] o_row;
    logic [COL_W-1:0] o_col;
    int failures = 0, num_checks = 0, nv = 0, ne = 0, rises = 0;
    always #5 i_clk_sys = ~i_clk_sys;
    mdcap_cmd_decoder #(.READ_LAT(2)) mdcap_cmd_decoder_i (.*);
    mdcap_ctrl_model mdcap_ctrl_model_i (.o_link_ck(i_link_ck), .o_cke(i_cke), .o_cs(i_cs),
        .o_ca(i_ca));
    ////////////////////////////////////////
    // Flags hold only until the next frame ends, so they are caught here along with pulse counts.
    always @(negedge i_clk_sys)
    begin
        nv += o_cmd_valid;
        ne += o_proto_err;
        if (o_cmd_valid === 1'b1)
        begin
            ap_c = o_auto_precharge_flag;
            b32_c = o_burst32;
            rfm_c = o_refresh_management;
        end
        if (o_dqs_oe_n === 1'b0 && o_dqs_out === 1'b1 && dqs_d === 1'b0)
            rises++;
        dqs_d = o_dqs_out;
    end
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // The answer lands two to three clocks after the last link rise.
    task automatic cmd(input logic [CA_W-1:0] a, b);
        mdcap_ctrl_model_i.send(1'b1, a, b);
        repeat (4) @(negedge i_clk_sys);
    endtask
    task automatic t_mode();
        cmd({1'b1, OPC_MRW1}, 6'h01);
        cmd({1'b0, OPC_MRW2}, 6'h08);
        chk(o_cmd_code, CMD_MRW);
        chk({o_pre_toggle, o_post_long}, 2'b11);
    endtask
    task automatic t_act(input logic [2:0] bk, input logic [16:0] r);
        int n0;
        n0 = nv;
        cmd({r[15:12], 2'b01}, {r[11:10], r[16], bk});
        cmd({r[9:6], 2'b11}, r[5:0]);
        chk(nv - n0, 1);
        chk(o_row, r);
        chk({o_bank, o_bank_sel}, {bk, 8'h01 << bk});
        chk(o_bank_open[bk], 1'b1);
    endtask
    // Read with auto precharge; the burst flag is set but on-the-fly is off.
    task automatic t_read(input logic [2:0] bk);
        int k;
        rises = 0;
        cmd({1'b1, OPC_RD1}, {2'b11, 1'b0, bk});
        cmd({1'b0, OPC_CAS2}, 6'h29);
        chk(o_cmd_code, CMD_RD);
        chk(o_col, 10'h2A4);
        chk({ap_c, b32_c, o_bank_open[bk]}, 3'b100);
        mdcap_ctrl_model_i.run(16);
        for (k = 0; k < 50 && o_strobe_busy !== 1'b0; k++)
            @(negedge i_clk_sys);
        if (k == 50)
        begin
            chk(o_strobe_busy, 1'b0);
            print_verdict();
        end
        chk(rises, 10);
        chk(o_dqs_oe_n, 1'b1);
    endtask
    task automatic t_write(input logic [2:0] bk);
        @(negedge i_clk_sys) i_otf_bl_en = 1'b1;
        cmd({1'b1, OPC_WR1}, {3'b000, bk});
        cmd({1'b0, OPC_CAS2}, 6'h04);
        chk(o_cmd_code, CMD_WR);
        chk({ap_c, b32_c, o_bank_open[bk], o_col}, {3'b011, 10'h010});
    endtask
    // Second halves with no first half, and a deselected frame, give no command.
    task automatic t_orphan();
        logic [CA_W-1:0] lone [3] = '{6'h03, {1'b0, OPC_CAS2}, {1'b0, OPC_MRW2}};
        int n0;
        int e0;
        n0 = nv;
        e0 = ne;
        mdcap_ctrl_model_i.send(1'b0, {1'b0, OPC_RD1}, 6'h05);
        foreach (lone[i]) cmd(lone[i], 6'h00);
        chk(ne - e0, 3);
        chk(nv - n0, 0);
    endtask
    task automatic t_ref_pre();
        cmd({1'b0, OPC_MPC}, 6'h05);
        mdcap_ctrl_model_i.run(2);
        chk(o_cmd_code, CMD_MPC);
        cmd({1'b0, OPC_REF}, 6'h0B);
        chk({o_cmd_code, rfm_c, o_bank_sel}, {CMD_REF, 1'b1, 8'h08});
        @(negedge i_clk_sys) i_rfm_required = 1'b0;
        cmd({1'b0, OPC_REF}, 6'h0B);
        chk(rfm_c, 1'b0);
        cmd({1'b1, OPC_PRE}, 6'h02);
        chk({o_bank_sel, o_bank_open}, 16'hFF00);
    endtask
    initial
    begin
        repeat (12) @(negedge i_clk_sys);
        i_arst_n = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        chk({o_dqs_oe_n, o_cmd_code, o_bank_open}, {1'b1, CMD_NONE, 8'h00});
        t_mode();
        // Banks open before access, spaced by whole tasks.
        t_act(3'd5, 17'h1B3C5);
        t_read(3'd5);
        t_act(3'd2, 17'h0A5A5);
        t_write(3'd2);
        t_orphan();
        t_ref_pre();
        print_verdict();
    end
endmodule
